// [pkg/rgc_pkg.sv]
/*
 Shared constants of the receive gain, level and channel filter block:
 register offsets, field positions, reset values and lookup tables.
 Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package rgc_pkg;
    // Register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WIDTH = 8'h04;
    localparam logic [7:0] OFS_LIMA = 8'h08;
    localparam logic [7:0] OFS_LIMB = 8'h0C;
    localparam logic [7:0] OFS_LIVE = 8'h10;
    localparam logic [7:0] OFS_PKT = 8'h14;
    // Field positions
    localparam int CTRL_COMP_LSB = 0;
    localparam int CTRL_AVG_LSB = 5;
    localparam int CTRL_CAL_BIT = 8;
    localparam int CTRL_BUSY_BIT = 16;
    localparam int WIDTH_EXP_LSB = 0;
    localparam int WIDTH_MANT_LSB = 3;
    localparam int LIVE_GAIN_LSB = 8;
    localparam int LIVE_MODEM_LSB = 16;
    localparam int PKT_SNR_LSB = 8;
    // Values after reset
    localparam logic [4:0] COMP_RST = 5'h00;
    localparam logic [2:0] AVG_RST = 3'h2;
    localparam logic [4:0] WIDTH_RST = 5'h15;
    localparam logic [7:0] LIM_RST [5] = '{8'hB0, 8'hBA, 8'hC4, 8'hCE, 8'hD8};
    // Gain step codes, weakest input first
    localparam logic [2:0] LNA_CODE [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    // Bandwidth mantissa codes 0..2 and their values
    localparam logic [1:0] MANT_RSVD = 2'h3;
    localparam logic [2:0] EXP_RSVD = 3'h0;
    localparam logic [4:0] MANT_VAL [3] = '{5'h10, 5'h14, 5'h18};
    // Channel filter taps, symmetric low pass
    localparam int FIR_TAPS = 16;
    localparam int FIR_COEF [16] = '{-1, -2, -3, 0, 8, 20, 32, 40, 40, 32, 20, 8, 0, -3, -2, -1};
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [logic/rgc_chan_fir.sv]
/*
 Sixteen-tap channel filter with a registered output.
 Assumes samples arrive with a one-cycle valid on the reference clock.
*/
`timescale 1ns/100ps
module rgc_chan_fir #(
    parameter int DATA_W = 12,
    parameter int COEF_W = 8,
    parameter int TAPS = rgc_pkg::FIR_TAPS,
    parameter int OUT_W = DATA_W + COEF_W + 4
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Sample in
    input wire logic signed [DATA_W-1:0] i_sample,
    input wire logic i_valid,
    // Filtered sample out
    output logic signed [OUT_W-1:0] o_sample,
    output logic o_valid
);
    import rgc_pkg::*;

    logic signed [DATA_W-1:0] tap_reg [TAPS];
    logic signed [DATA_W-1:0] tap_next [TAPS];
    logic signed [OUT_W-1:0] sum_next;
    logic signed [OUT_W-1:0] out_reg;
    logic valid_reg;

    // Delay line, one stage per tap
    genvar k;
    generate
        for (k = 0; k < TAPS; k++) begin : g_tap
            always_comb begin
                tap_next[k] = tap_reg[k];
                if (i_valid) begin
                    tap_next[k] = (k == 0) ? i_sample : tap_reg[(k == 0) ? 0 : k - 1];
                end
            end
            always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    tap_reg[k] <= '0;
                end else begin
                    tap_reg[k] <= tap_next[k];
                end
            end
        end
    endgenerate

    // Weighted sum over the new window, so output lags input by one cycle
    always_comb begin
        sum_next = '0;
        for (int j = 0; j < TAPS; j++) begin
            sum_next = OUT_W'(sum_next + OUT_W'(tap_next[j]) * OUT_W'($signed(COEF_W'(FIR_COEF[j]))));
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            out_reg <= i_valid ? sum_next : out_reg;
            valid_reg <= i_valid;
        end
    end

    assign o_sample = out_reg;
    assign o_valid = valid_reg;

    a_fir_valid: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        i_valid |=> o_valid) else $error("Filter output valid missing");
endmodule // rgc_chan_fir

// [logic/rgc_rx_level.sv]
/*
 Receive gain step selection, signal level measurement with averaging,
 spread-spectrum modem level capture, channel width setting and the
 channel filter, behind an AXI4-Lite register slave.
 Assumes front end and modem inputs are produced on the reference clock.
*/
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
// Operation
// - Six gain steps chosen from five ascending limits
// - Reading is minus twice level plus compensation
// - Compensation spans -16 to +15 dB
// - Average over two to 256 samples
// - Sample rate four times bandwidth sets response
// - Calibration launch restarts level measurement
// - Packet level averages live level; live always readable
// - Channel filter is sixteen-tap FIR
// - Bandwidth is reference over mantissa times power
// - Mantissa codes 16,20,24; exponent 1 to 7
module rgc_rx_level (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // AXI4-Lite write
    input wire logic [rgc_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read
    input wire logic [rgc_pkg::ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Front end
    input wire logic signed [7:0] i_rf_level,
    input wire logic signed [11:0] i_if_sample,
    input wire logic i_if_valid,
    // Spread-spectrum modem
    input wire logic [7:0] i_modem_level,
    input wire logic [7:0] i_noise_ratio,
    input wire logic i_header_valid_event,
    input wire logic i_receive_done_event,
    // Results
    output logic [2:0] o_lna_gain_code,
    output logic [7:0] o_signal_level_reading,
    output logic signed [23:0] o_filt_sample,
    output logic o_filt_valid
);
    import rgc_pkg::*;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_arst_n);

    // Bus state
    logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic do_write;
    // Settings
    logic [4:0] comp_reg, comp_next, width_reg, width_next;
    logic [2:0] avg_reg, avg_next;
    logic [7:0] lim_reg [5];
    logic [7:0] lim_next [5];
    logic cal_start;
    // Measurement state
    logic [12:0] div_reg, div_next, period;
    logic sample_en;
    logic [7:0] cnt_reg, cnt_next, target_cnt, lvl, reading_reg, reading_next;
    logic [15:0] acc_reg, acc_next, acc_sum;
    logic signed [10:0] lvl_full;
    logic cal_busy_reg, cal_busy_next;
    logic [2:0] gain_reg, gain_next;
    // Modem state
    logic [7:0] live_reg, pkt_avg_reg, pkt_avg_next, pkt_lvl_reg, pkt_lvl_next;
    logic [7:0] snr_reg, snr_next;
    logic signed [9:0] pkt_diff;

    // Handshakes; one write and one read in flight
    assign o_awready = !aw_hold_reg && !bvalid_reg;
    assign o_wready = !w_hold_reg && !bvalid_reg;
    assign o_arready = !rvalid_reg;
    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

    // Address and data are latched apart so either may come first
    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next = w_hold_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (i_awvalid && o_awready) begin
            aw_hold_next = 1'b1;
            aw_addr_next = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            w_hold_next = 1'b1;
            w_data_next = i_wdata;
            w_strb_next = i_wstrb;
        end
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (aw_addr_reg <= OFS_PKT && aw_addr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && i_bready) begin
            bvalid_next = 1'b0;
        end
    end

    // Read answer is registered one cycle after the address is taken
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (i_arvalid && o_arready) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = '0;
            unique case (i_araddr)
                OFS_CTRL: begin
                    rdata_next[CTRL_COMP_LSB +: 5] = comp_reg;
                    rdata_next[CTRL_AVG_LSB +: 3] = avg_reg;
                    rdata_next[CTRL_BUSY_BIT] = cal_busy_reg;
                end
                OFS_WIDTH: rdata_next[4:0] = width_reg;
                OFS_LIMA: rdata_next = {lim_reg[3], lim_reg[2], lim_reg[1], lim_reg[0]};
                OFS_LIMB: rdata_next[7:0] = lim_reg[4];
                OFS_LIVE: begin
                    rdata_next[7:0] = reading_reg;
                    rdata_next[LIVE_GAIN_LSB +: 3] = gain_reg;
                    rdata_next[LIVE_MODEM_LSB +: 8] = live_reg;
                end
                OFS_PKT: begin
                    rdata_next[7:0] = pkt_lvl_reg;
                    rdata_next[PKT_SNR_LSB +: 8] = snr_reg;
                end
                default: rresp_next = RESP_SLVERR;
            endcase
        end else if (rvalid_reg && i_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // Settings written through byte strobes
    always_comb begin
        comp_next = comp_reg;
        avg_next = avg_reg;
        width_next = width_reg;
        lim_next = lim_reg;
        cal_start = 1'b0;
        if (do_write && aw_addr_reg == OFS_CTRL && w_strb_reg[0]) begin
            comp_next = w_data_reg[CTRL_COMP_LSB +: 5];
            avg_next = w_data_reg[CTRL_AVG_LSB +: 3];
        end
        if (do_write && aw_addr_reg == OFS_CTRL && w_strb_reg[1]) begin
            cal_start = w_data_reg[CTRL_CAL_BIT];
        end
        // Reserved codes would give a bogus divider period, so they are dropped
        if (do_write && aw_addr_reg == OFS_WIDTH && w_strb_reg[0]
            && w_data_reg[WIDTH_MANT_LSB +: 2] != MANT_RSVD
            && w_data_reg[WIDTH_EXP_LSB +: 3] != EXP_RSVD) begin
            width_next = w_data_reg[4:0];
        end
        for (int b = 0; b < 4; b++) begin
            if (do_write && aw_addr_reg == OFS_LIMA && w_strb_reg[b]) begin
                lim_next[b] = w_data_reg[8*b +: 8];
            end
        end
        if (do_write && aw_addr_reg == OFS_LIMB && w_strb_reg[0]) begin
            lim_next[4] = w_data_reg[7:0];
        end
    end

    // Sample rate is four times the bandwidth: one sample per mantissa times 2^exp clocks
    assign period = 13'({8'h00, MANT_VAL[width_reg[WIDTH_MANT_LSB +: 2]]} << width_reg[WIDTH_EXP_LSB +: 3]);
    assign sample_en = (div_reg >= 13'(period - 13'h0001)); // Shorter period after a width write must not overrun
    assign div_next = sample_en ? 13'h0000 : 13'(div_reg + 13'h0001);

    // Level in half-dB units, clamped into the unsigned reading range
    assign lvl_full = {{6{comp_reg[4]}}, comp_reg} - ({{3{i_rf_level[7]}}, i_rf_level} <<< 1);
    assign lvl = (lvl_full < 0) ? 8'h00 : (lvl_full > 11'sd255) ? 8'hFF : lvl_full[7:0];
    assign target_cnt = 8'((9'h002 << avg_reg) - 9'h001);
    assign acc_sum = 16'(acc_reg + {8'h00, lvl});

    // Averaging block; a calibration launch restarts it and wins over completion
    always_comb begin
        acc_next = acc_reg;
        cnt_next = cnt_reg;
        reading_next = reading_reg;
        cal_busy_next = cal_busy_reg;
        if (sample_en) begin
            acc_next = acc_sum;
            cnt_next = 8'(cnt_reg + 8'h01);
            if (cnt_reg >= target_cnt) begin
                reading_next = 8'(acc_sum >> (4'(avg_reg) + 4'h1));
                acc_next = '0;
                cnt_next = '0;
                cal_busy_next = 1'b0;
            end
        end
        if (cal_start) begin
            acc_next = '0;
            cnt_next = '0;
            cal_busy_next = 1'b1;
        end
    end

    // Gain step from five ascending limits
    always_comb begin
        gain_next = LNA_CODE[5];
        for (int s = 4; s >= 0; s--) begin
            if (i_rf_level <= $signed(lim_reg[s])) begin
                gain_next = LNA_CODE[s];
            end
        end
    end

    // Packet level is a running quarter-step average seeded at header
    assign pkt_diff = $signed({2'b00, live_reg}) - $signed({2'b00, pkt_avg_reg});
    always_comb begin
        pkt_avg_next = pkt_avg_reg;
        pkt_lvl_next = pkt_lvl_reg;
        snr_next = snr_reg;
        if (i_header_valid_event) begin
            pkt_avg_next = live_reg;
        end else if (sample_en) begin
            pkt_avg_next = 8'($signed({2'b00, pkt_avg_reg}) + (pkt_diff >>> 2));
        end
        if (i_receive_done_event) begin
            pkt_lvl_next = pkt_avg_reg;
            snr_next = i_noise_ratio;
        end
    end

    // All state registers
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_hold_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
            comp_reg <= COMP_RST;
            avg_reg <= AVG_RST;
            width_reg <= WIDTH_RST;
            lim_reg <= LIM_RST;
            div_reg <= '0;
            acc_reg <= '0;
            cnt_reg <= '0;
            reading_reg <= '0;
            cal_busy_reg <= 1'b0;
            gain_reg <= LNA_CODE[0];
            live_reg <= '0;
            pkt_avg_reg <= '0;
            pkt_lvl_reg <= '0;
            snr_reg <= '0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg <= w_hold_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            comp_reg <= comp_next;
            avg_reg <= avg_next;
            width_reg <= width_next;
            lim_reg <= lim_next;
            div_reg <= div_next;
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
            reading_reg <= reading_next;
            cal_busy_reg <= cal_busy_next;
            gain_reg <= gain_next;
            live_reg <= i_modem_level;
            pkt_avg_reg <= pkt_avg_next;
            pkt_lvl_reg <= pkt_lvl_next;
            snr_reg <= snr_next;
        end
    end

    // Channel filter
    rgc_chan_fir #(
        .DATA_W(12),
        .COEF_W(8),
        .TAPS(FIR_TAPS),
        .OUT_W(24)
    ) u_fir (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_sample(i_if_sample),
        .i_valid(i_if_valid),
        .o_sample(o_filt_sample),
        .o_valid(o_filt_valid)
    );

    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;
    assign o_lna_gain_code = gain_reg;
    assign o_signal_level_reading = reading_reg;

    a_gain_weak: assert property ($signed(i_rf_level) <= $signed(lim_reg[0]) |=> gain_reg == 3'h1)
        else $error("Weak input not at first gain step");
    a_gain_strong: assert property ($signed(i_rf_level) > $signed(lim_reg[4]) |=> gain_reg == 3'h7)
        else $error("Strong input not at last gain step");
    a_gain_legal: assert property (gain_reg != 3'h0 && gain_reg != 3'h5)
        else $error("Illegal gain step code");
    a_level_formula: assert property (sample_en && i_rf_level == -8'sd40 && comp_reg == 5'h00
        |-> lvl == 8'h50) else $error("Level reading formula wrong");
    a_avg_block: assert property (sample_en && cnt_reg == target_cnt && !cal_start
        |=> cnt_reg == 8'h00 && acc_reg == 16'h0000) else $error("Averaging block did not close");
    a_sample_gap: assert property (sample_en && width_reg == 5'h01 |=> !sample_en [*8] ##24 sample_en)
        else $error("Sample period wrong for setting");
    a_cal_restart: assert property (cal_start |=> cal_busy_reg && cnt_reg == 8'h00)
        else $error("Calibration did not restart averaging");
    a_pkt_capture: assert property (i_receive_done_event |=> pkt_lvl_reg == $past(pkt_avg_reg))
        else $error("Packet level not captured at end");
    a_width_legal: assert property (width_reg[4:3] != 2'h3 && width_reg[2:0] != 3'h0)
        else $error("Reserved channel width stored");
    a_bus_resp: assert property (do_write |=> o_bvalid [*1] ##0 !o_awready)
        else $error("Write response missing");
endmodule // rgc_rx_level

// [verif/rgc_front_end_model.sv]
/*
 Behavioural front end: antenna level and IF sample stream.
 Assumes the bench names the level and asks for one impulse burst.
*/
`timescale 1ns/100ps
module rgc_front_end_model (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Commands from the bench
    input wire logic signed [7:0] i_level,
    input wire logic i_impulse,
    // Receiver input
    output logic signed [7:0] o_rf_level,
    output logic signed [11:0] o_if_sample,
    output logic o_if_valid
);
    localparam int AMP = 16;
    int left;
    int gap;
    // Burst of sixteen samples, one every third cycle; garbage between them
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rf_level <= 8'sh00;
            o_if_sample <= 12'sh000;
            o_if_valid <= 1'b0;
            left <= 0;
            gap <= 0;
        end else begin
            o_rf_level <= i_level;
            o_if_valid <= 1'b0;
            o_if_sample <= ~o_if_sample; // Sample is not held outside valid
            if (i_impulse) begin
                left <= 16;
                gap <= 0;
            end else if (left > 0 && gap == 0) begin
                o_if_valid <= 1'b1;
                o_if_sample <= (left == 16) ? 12'(AMP) : 12'sh000;
                left <= left - 1;
                gap <= 2;
            end else if (gap > 0) begin
                gap <= gap - 1;
            end
        end
    end
endmodule // rgc_front_end_model

// [verif/test_rgc_rx_level.sv]
/*
 Self-checking bench of the receive level block over AXI4-Lite.
 Assumes the front end model and a 20 MHz reference clock.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module test_rgc_rx_level;
    import rgc_pkg::*;
    logic clk = 0, rst_n = 0;
    logic [7:0] awaddr = 0, araddr = 0, mlev = 0, nratio = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, hdr = 0, done = 0, imp = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, ifv, fv;
    logic signed [7:0] lev = 0, rfl;
    logic signed [11:0] ifs;
    logic [2:0] gain;
    logic [7:0] rdg;
    logic signed [23:0] fs;
    int err_count = 0, checks = 0, cyc = 0;
    always #25 clk = ~clk;
    rgc_front_end_model i_fe (.i_ref_clk(clk), .i_arst_n(rst_n), .i_level(lev), .i_impulse(imp),
        .o_rf_level(rfl), .o_if_sample(ifs), .o_if_valid(ifv));
    rgc_rx_level i_dut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_rf_level(rfl), .i_if_sample(ifs), .i_if_valid(ifv), .i_modem_level(mlev),
        .i_noise_ratio(nratio), .i_header_valid_event(hdr), .i_receive_done_event(done),
        .o_lna_gain_code(gain), .o_signal_level_reading(rdg), .o_filt_sample(fs), .o_filt_valid(fv));
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard, well above the longest averaging wait
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            finish_test();
        end
    end
    // Write one word; address and data released as each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ad = 0, dd = 0;
        awaddr <= a; awvalid <= 1; wdata <= d; wstrb <= 4'hF; wvalid <= 1; bready <= 1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (awvalid && awready) begin ad = 1; awvalid <= 0; end
            if (wvalid && wready) begin dd = 1; wvalid <= 0; end
        end
        do @(posedge clk); while (!bvalid);
        `CHK("bresp", er, bresp)
        bready <= 0;
        @(posedge clk);
    endtask
    // Read one word and compare data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m, input logic [1:0] er);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge clk); while (!arready);
        arvalid <= 0;
        do @(posedge clk); while (!rvalid);
        `CHK("rresp", er, rresp)
        `CHK("rdata", ed & m, rdata & m)
        rready <= 0;
        @(posedge clk);
    endtask
    // Reset values and unmapped access
    task automatic t_regs();
        rd(OFS_CTRL, 32'h0000_0040, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFS_WIDTH, 32'h0000_0015, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFS_LIMA, 32'hCEC4_BAB0, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFS_LIMB, 32'h0000_00D8, 32'hFFFF_FFFF, RESP_OKAY);
        rd(8'h18, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
        wr(8'h02, 32'h0000_0001, RESP_SLVERR);
    endtask
    // Gain steps across every limit, boundaries of the first and last limits included
    task automatic t_gain();
        logic signed [7:0] lv [8] = '{-90, -80, -79, -65, -55, -41, -40, -39};
        logic [2:0] ex [8] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h6, 3'h7};
        for (int k = 0; k < 8; k++) begin
            lev <= lv[k];
            repeat (4) @(posedge clk);
            `CHK("gain", ex[k], gain)
        end
    endtask
    // Reserved widths are dropped, legal ones kept
    task automatic t_width();
        wr(OFS_WIDTH, 32'h0000_0019, RESP_OKAY);
        rd(OFS_WIDTH, 32'h0000_0015, 32'h0000_001F, RESP_OKAY);
        wr(OFS_WIDTH, 32'h0000_0008, RESP_OKAY);
        rd(OFS_WIDTH, 32'h0000_0015, 32'h0000_001F, RESP_OKAY);
        for (int m = 0; m < 3; m++) begin
            wr(OFS_WIDTH, 32'(m * 8 + 7), RESP_OKAY);
            rd(OFS_WIDTH, 32'(m * 8 + 7), 32'h0000_001F, RESP_OKAY);
        end
        // Widest bandwidth: fastest sampling keeps averaging short and leaves room for the bit rate
        wr(OFS_WIDTH, 32'h0000_0001, RESP_OKAY);
    endtask
    // Level reading: offset, averaging count and clamping
    task automatic t_level(input logic signed [7:0] l, input logic [31:0] c, input int w, input logic [7:0] e);
        lev <= l;
        wr(OFS_CTRL, c, RESP_OKAY);
        repeat (w) @(posedge clk);
        `CHK("reading", e, rdg)
    endtask
    // Calibration launch shows busy until the next average completes
    task automatic t_cal();
        wr(OFS_CTRL, 32'h0000_0100, RESP_OKAY);
        rd(OFS_CTRL, 32'h0001_0000, 32'h0001_0100, RESP_OKAY);
        repeat (300) @(posedge clk);
        rd(OFS_CTRL, 32'h0000_0000, 32'h0001_0100, RESP_OKAY);
    endtask
    // Live field always readable, packet capture between the events
    task automatic t_packet();
        mlev <= 8'h5A;
        nratio <= 8'hF4;
        repeat (3) @(posedge clk);
        rd(OFS_LIVE, 32'h005A_0000, 32'h00FF_0000, RESP_OKAY);
        wr(OFS_LIVE, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFS_LIVE, 32'h005A_0000, 32'h00FF_0000, RESP_OKAY);
        hdr <= 1;
        @(posedge clk);
        hdr <= 0;
        mlev <= 8'h6A; // Average must climb from the seed towards the new level
        repeat (20) @(posedge clk);
        rd(OFS_LIVE, 32'h006A_0000, 32'h00FF_0000, RESP_OKAY);
        repeat (300) @(posedge clk);
        done <= 1;
        @(posedge clk);
        done <= 0;
        repeat (3) @(posedge clk);
        rd(OFS_PKT, 32'h0000_F467, 32'h0000_FFFF, RESP_OKAY);
    endtask
    // Impulse response of the channel filter equals its tap set times the impulse amplitude of 16
    task automatic t_fir();
        logic signed [23:0] e;
        imp <= 1;
        @(posedge clk);
        imp <= 0;
        for (int k = 0; k < FIR_TAPS; k++) begin
            do @(posedge clk); while (!ifv);
            @(posedge clk);
            e = 24'(16 * FIR_COEF[k]);
            `CHK("filt_valid", 1'b1, fv)
            `CHK("filt_sample", e, fs)
        end
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        t_regs();
        t_gain();
        t_width();
        t_level(-50, 32'h0000_0010, 200, 8'h54);
        t_level(-60, 32'h0000_006F, 1200, 8'h87);
        t_level(-60, 32'h0000_00EF, 8500, 8'h87);
        t_level(20, 32'h0000_0000, 200, 8'h00);
        t_level(-128, 32'h0000_000F, 200, 8'hFF);
        t_level(-40, 32'h0000_0000, 200, 8'h50);
        t_cal();
        t_packet();
        t_fir();
        finish_test();
    end
endmodule // test_rgc_rx_level
